// File: hdl/usr_consts.svh
// Operation
// - The interrupt mask gates receive-data, transmit-empty, line-status and modem-status interrupts into the source code.
// - With FIFOs on and receive interrupt enabled, the receive interrupt stands while the fill is at or above the trigger.
// - The source register shows the receive-level code while the trigger is reached and no line-status source is pending, and drops it with the interrupt.
// - Data-ready sets as soon as a character enters the receive FIFO and clears only when the FIFO is empty.
// - FIFOs on with mask bits 0 to 3 clear gives polled mode, where only the line flags and the GPIO interrupt, which the mask does not gate, report state.
// - Receive and transmit state sit in separate line flags, so each side may be polled on its own.
// - Line flag bit 1 sets on a receive overrun.
// - Line flag bits 2 to 4 give the error kind of the character at the head of the receive FIFO.
// - Line flag bit 5 is high whenever the transmit holding position is empty.
// - Line flag bit 6 is high only when transmit FIFO and transmit shifter are both empty.
// - Line flag bit 7 is high while any character in the receive FIFO carries an error.
// - Enhanced bit 4 unlocks the enhanced fields, and the enhanced register sits at 0x02 only when line format is 0xbf.
// - A toggle of an enabled GPIO input raises the GPIO interrupt, and a read of the pin state clears it.
`ifndef USR_CONSTS_SVH
`define USR_CONSTS_SVH

// Register offsets
`define USR_OFS_HOLD    4'h0
`define USR_OFS_MASK    4'h1
`define USR_OFS_SETUP   4'h2
`define USR_OFS_FORMAT  4'h3
`define USR_OFS_MODEM   4'h4
`define USR_OFS_FLAGS   4'h5
`define USR_OFS_MSTAT   4'h6
`define USR_OFS_SCRATCH 4'h7
`define USR_OFS_TXLVL   4'h8
`define USR_OFS_RXLVL   4'h9
`define USR_OFS_IODIR   4'ha
`define USR_OFS_GPIO_PIN_STATE 4'hb
`define USR_OFS_IOINTEN 4'hc
`define USR_OFS_RSVD    4'hd
`define USR_OFS_IOCTRL  4'he
`define USR_OFS_EXTRA   4'hf

// Access key and field positions
`define USR_ENH_KEY     8'hbf
`define USR_DIV_BIT     7
`define USR_ENH_BIT     4
`define USR_SWRST_BIT   3
`define USR_FIFO_EN_BIT 0

// Reset values
`define USR_RST_BYTE    8'h00

// Receive trigger levels selected by setup bits 7:6
`define USR_TRIG_0      8'h08
`define USR_TRIG_1      8'h10
`define USR_TRIG_2      8'h38
`define USR_TRIG_3      8'h3c

`endif

// File: hdl/usr_pkg.sv
package usr_pkg;

  typedef logic [7:0] usr_byte_t;

  // Interrupt source codes, highest priority first
  typedef enum logic [5:0] {
    USR_SRC_LINE  = 6'h06,
    USR_SRC_RXRDY = 6'h04,
    USR_SRC_TXRDY = 6'h02,
    USR_SRC_MODEM = 6'h00,
    USR_SRC_GPIO  = 6'h30,
    USR_SRC_NONE  = 6'h01
  } usr_src_t;

endpackage

// File: hdl/usr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "usr_consts.svh"

module usr_regs
  import usr_pkg::*;
#(
  parameter int RX_DEPTH = 64
)(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output var  logic [7:0]  reg_rdata_out,
  output var  logic        reg_rvalid_out,
  input  wire logic        rx_push_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic [2:0]  rx_err_in,
  input  wire logic        tx_fifo_empty_in,
  input  wire logic        tx_shift_empty_in,
  input  wire logic [7:0]  tx_level_in,
  input  wire logic [7:0]  modem_status_in,
  input  wire logic        modem_event_in,
  input  wire logic [7:0]  gpio_in,
  output var  logic        tx_push_out,
  output var  logic [7:0]  tx_data_out,
  output var  logic [15:0] baud_div_out,
  output var  logic [7:0]  frac_div_out,
  output var  logic [7:0]  line_format_out,
  output var  logic [7:0]  fifo_setup_out,
  output var  logic [7:0]  modem_ctrl_out,
  output var  logic [7:0]  enh_ctrl_out,
  output var  logic [7:0]  extra_ctrl_out,
  output var  logic [7:0]  gpio_out,
  output var  logic [7:0]  gpio_dir_out,
  output var  logic [3:0]  gpio_ctrl_out,
  output var  logic        irq_out
);

  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);

  // Trigger level from setup bits 7:6
  function automatic logic [7:0] trig_lvl(input logic [1:0] sel);
    logic [7:0] lvl;
    lvl = `USR_TRIG_0;
    case (sel)
      2'h1: lvl = `USR_TRIG_1;
      2'h2: lvl = `USR_TRIG_2;
      2'h3: lvl = `USR_TRIG_3;
      default: lvl = `USR_TRIG_0;
    endcase
    return lvl;
  endfunction

  usr_byte_t        format_reg, mask_reg, setup_reg, enh_reg, modem_reg, scratch_reg;
  usr_byte_t        dll_reg, dlm_reg, dld_reg, extra_reg, iodir_reg, gpio_pin_state_reg, ioinen_reg;
  usr_byte_t        flow_reg [4];
  logic [3:0]       ioctl_reg;
  logic [10:0]      rx_mem_reg [RX_DEPTH];
  logic [PW-1:0]    wptr_reg, rptr_reg;
  logic [CW-1:0]    cnt_reg, errcnt_reg;
  logic             overrun_reg, gpio_irq_reg;
  usr_byte_t        gpio_prev_reg;
  usr_byte_t        rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Access windows and strobes
  wire enh_acc  = (format_reg == `USR_ENH_KEY);
  wire div_acc  = format_reg[`USR_DIV_BIT] & ~enh_acc;
  wire enh_on   = enh_reg[`USR_ENH_BIT];
  wire fifo_en  = setup_reg[`USR_FIFO_EN_BIT];
  wire at_hold  = (reg_addr_in == `USR_OFS_HOLD);
  wire at_mask  = (reg_addr_in == `USR_OFS_MASK);
  wire at_setup = (reg_addr_in == `USR_OFS_SETUP);
  wire at_flow  = (reg_addr_in[3:2] == 2'h1);
  wire wr_thr   = reg_wr_in & at_hold & ~div_acc;
  wire wr_dll   = reg_wr_in & at_hold & div_acc;
  wire wr_mask  = reg_wr_in & at_mask & ~div_acc;
  wire wr_dlm   = reg_wr_in & at_mask & div_acc;
  wire wr_fcr   = reg_wr_in & at_setup & ~div_acc & ~enh_acc;
  wire wr_efr   = reg_wr_in & at_setup & enh_acc;
  wire wr_dld   = reg_wr_in & at_setup & div_acc & enh_on;
  wire wr_flow  = reg_wr_in & at_flow & enh_acc;
  wire wr_mcr   = reg_wr_in & (reg_addr_in == `USR_OFS_MODEM) & ~enh_acc;
  wire wr_spr   = reg_wr_in & (reg_addr_in == `USR_OFS_SCRATCH) & ~enh_acc;
  wire wr_at    = reg_wr_in & reg_addr_in[3];
  wire rd_rhr   = reg_rd_in & at_hold & ~div_acc;
  wire rd_flags = reg_rd_in & (reg_addr_in == `USR_OFS_FLAGS) & ~enh_acc;
  wire rd_iost  = reg_rd_in & (reg_addr_in == `USR_OFS_GPIO_PIN_STATE);
  wire swrst    = wr_at & (reg_addr_in == `USR_OFS_IOCTRL) & reg_wdata_in[`USR_SWRST_BIT];

  // Enhanced fields pass only while unlocked
  wire [7:0] mask_wr = {enh_on ? reg_wdata_in[7:4] : mask_reg[7:4], reg_wdata_in[3:0]};
  wire [7:0] fcr_wr  = {reg_wdata_in[7:6], enh_on ? reg_wdata_in[5:4] : setup_reg[5:4],
                        reg_wdata_in[3:0]};
  wire [7:0] mcr_wr  = {enh_on ? reg_wdata_in[7:5] : modem_reg[7:5], reg_wdata_in[4:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO status
  wire rx_empty = (cnt_reg == '0);
  wire rx_full  = fifo_en ? (cnt_reg == CW'(RX_DEPTH)) : ~rx_empty;
  wire rx_push  = rx_push_in & ~rx_full;
  wire rx_pop   = rd_rhr & ~rx_empty;
  wire push_err = rx_push & (rx_err_in != 3'h0);
  wire [10:0] head = rx_mem_reg[rptr_reg];
  wire pop_err  = rx_pop & (head[10:8] != 3'h0);
  wire [7:0] rx_fill = 8'(cnt_reg);
  wire [7:0] rx_trig = fifo_en ? trig_lvl(setup_reg[7:6]) : 8'h01;

  // Line condition flags
  wire [7:0] flags = {errcnt_reg != '0,
                      tx_fifo_empty_in & tx_shift_empty_in,
                      tx_fifo_empty_in,
                      rx_empty ? 3'h0 : head[10:8],
                      overrun_reg,
                      ~rx_empty};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources in priority order
  wire src_line = mask_reg[2] & (flags[7] | flags[1]);
  wire src_rx   = mask_reg[0] & (rx_fill >= rx_trig);
  wire src_tx   = mask_reg[1] & tx_fifo_empty_in;
  wire src_mdm  = mask_reg[3] & modem_event_in;
  wire [5:0] src_code = src_line ? USR_SRC_LINE  :
                        src_rx   ? USR_SRC_RXRDY :
                        src_tx   ? USR_SRC_TXRDY :
                        src_mdm  ? USR_SRC_MODEM :
                        gpio_irq_reg ? USR_SRC_GPIO : USR_SRC_NONE;
  wire [7:0] isr_val = {fifo_en, fifo_en, src_code};
  wire [7:0] gpio_tog = (gpio_in ^ gpio_prev_reg) & ioinen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  always_comb
  begin
    rd_mux = `USR_RST_BYTE;
    if (at_hold)
      rd_mux = div_acc ? dll_reg : head[7:0];
    else if (at_mask)
      rd_mux = div_acc ? dlm_reg : mask_reg;
    else if (at_setup)
      rd_mux = enh_acc ? enh_reg : (div_acc ? dld_reg : isr_val);
    else if (reg_addr_in == `USR_OFS_FORMAT)
      rd_mux = format_reg;
    else if (at_flow && enh_acc)
      rd_mux = flow_reg[reg_addr_in[1:0]];
    else if (reg_addr_in == `USR_OFS_MODEM)
      rd_mux = modem_reg;
    else if (reg_addr_in == `USR_OFS_FLAGS)
      rd_mux = flags;
    else if (reg_addr_in == `USR_OFS_MSTAT)
      rd_mux = modem_status_in;
    else if (reg_addr_in == `USR_OFS_SCRATCH)
      rd_mux = scratch_reg;
    else if (reg_addr_in == `USR_OFS_TXLVL)
      rd_mux = tx_level_in;
    else if (reg_addr_in == `USR_OFS_RXLVL)
      rd_mux = rx_fill;
    else if (reg_addr_in == `USR_OFS_IODIR)
      rd_mux = iodir_reg;
    else if (reg_addr_in == `USR_OFS_GPIO_PIN_STATE)
      rd_mux = gpio_in;
    else if (reg_addr_in == `USR_OFS_IOINTEN)
      rd_mux = ioinen_reg;
    else if (reg_addr_in == `USR_OFS_IOCTRL)
      rd_mux = {4'h0, ioctl_reg};
    else if (reg_addr_in == `USR_OFS_EXTRA)
      rd_mux = extra_reg;
    else
      rd_mux = `USR_RST_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core control registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      format_reg <= `USR_RST_BYTE;
      mask_reg   <= `USR_RST_BYTE;
      setup_reg  <= `USR_RST_BYTE;
      enh_reg    <= `USR_RST_BYTE;
      modem_reg  <= `USR_RST_BYTE;
      dll_reg    <= `USR_RST_BYTE;
      dlm_reg    <= `USR_RST_BYTE;
      dld_reg    <= `USR_RST_BYTE;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `USR_OFS_FORMAT) format_reg <= reg_wdata_in;
      if (wr_mask) mask_reg  <= mask_wr;
      if (wr_fcr)  setup_reg <= fcr_wr;
      if (wr_efr)  enh_reg   <= reg_wdata_in;
      if (wr_mcr)  modem_reg <= mcr_wr;
      if (wr_dll)  dll_reg   <= reg_wdata_in;
      if (wr_dlm)  dlm_reg   <= reg_wdata_in;
      if (wr_dld)  dld_reg   <= reg_wdata_in;
    end
  end

  // Flow characters, one per offset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flow
      always_ff @(posedge mclk_in)
      begin
        if (rst_in)
          flow_reg[gi] <= `USR_RST_BYTE;
        else if (wr_flow && reg_addr_in[1:0] == 2'(gi))
          flow_reg[gi] <= reg_wdata_in;
      end
    end
  endgenerate

  // Scratch pad and upper block: GPIO and extra features; reserved slot ignored
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      scratch_reg <= `USR_RST_BYTE;
      iodir_reg   <= `USR_RST_BYTE;
      gpio_pin_state_reg <= `USR_RST_BYTE;
      ioinen_reg  <= `USR_RST_BYTE;
      ioctl_reg   <= 4'h0;
      extra_reg   <= `USR_RST_BYTE;
    end
    else
    begin
      if (wr_spr) scratch_reg <= reg_wdata_in;
      if (wr_at && reg_addr_in == `USR_OFS_IODIR)   iodir_reg   <= reg_wdata_in;
      if (wr_at && reg_addr_in == `USR_OFS_GPIO_PIN_STATE) gpio_pin_state_reg <= reg_wdata_in;
      if (wr_at && reg_addr_in == `USR_OFS_IOINTEN) ioinen_reg  <= reg_wdata_in;
      if (wr_at && reg_addr_in == `USR_OFS_IOCTRL)  ioctl_reg   <= {1'b0, reg_wdata_in[2:0]};  // Reset bit self-clears
      if (wr_at && reg_addr_in == `USR_OFS_EXTRA)   extra_reg   <= {reg_wdata_in[7], 1'b0, reg_wdata_in[5:4],
                                                                    1'b0, reg_wdata_in[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO storage and pointers
  always_ff @(posedge mclk_in)
  begin
    if (rx_push)
      rx_mem_reg[wptr_reg] <= {rx_err_in, rx_data_in};
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || swrst || (wr_fcr && reg_wdata_in[1]))
    begin
      wptr_reg   <= '0;
      rptr_reg   <= '0;
      cnt_reg    <= '0;
      errcnt_reg <= '0;
    end
    else
    begin
      if (rx_push) wptr_reg <= wptr_reg + PW'(1);
      if (rx_pop)  rptr_reg <= rptr_reg + PW'(1);
      cnt_reg    <= cnt_reg + CW'(rx_push) - CW'(rx_pop);
      errcnt_reg <= errcnt_reg + CW'(push_err) - CW'(pop_err);
    end
  end

  // Overrun and GPIO sticky flags; a new event beats the clearing read
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      overrun_reg   <= 1'b0;
      gpio_irq_reg  <= 1'b0;
      gpio_prev_reg <= `USR_RST_BYTE;
    end
    else
    begin
      overrun_reg   <= (rx_push_in & rx_full) | (overrun_reg & ~rd_flags);
      gpio_irq_reg  <= (gpio_tog != 8'h00) | (gpio_irq_reg & ~rd_iost);
      gpio_prev_reg <= gpio_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out  <= `USR_RST_BYTE;
      reg_rvalid_out <= 1'b0;
      tx_push_out    <= 1'b0;
      tx_data_out    <= `USR_RST_BYTE;
      irq_out        <= 1'b0;
    end
    else
    begin
      reg_rdata_out  <= reg_rd_in ? rd_mux : `USR_RST_BYTE;
      reg_rvalid_out <= reg_rd_in;
      tx_push_out    <= wr_thr;
      if (wr_thr) tx_data_out <= reg_wdata_in;
      irq_out        <= (src_code != USR_SRC_NONE);
    end
  end

  // Configuration mirrors
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      baud_div_out    <= 16'h0000;
      frac_div_out    <= `USR_RST_BYTE;
      line_format_out <= `USR_RST_BYTE;
      fifo_setup_out  <= `USR_RST_BYTE;
      modem_ctrl_out  <= `USR_RST_BYTE;
      enh_ctrl_out    <= `USR_RST_BYTE;
      extra_ctrl_out  <= `USR_RST_BYTE;
      gpio_out        <= `USR_RST_BYTE;
      gpio_dir_out    <= `USR_RST_BYTE;
      gpio_ctrl_out   <= 4'h0;
    end
    else
    begin
      baud_div_out    <= {dlm_reg, dll_reg};
      frac_div_out    <= dld_reg;
      line_format_out <= format_reg;
      fifo_setup_out  <= setup_reg;
      modem_ctrl_out  <= modem_reg;
      enh_ctrl_out    <= enh_reg;
      extra_ctrl_out  <= extra_reg;
      gpio_out        <= gpio_pin_state_reg;
      gpio_dir_out    <= iodir_reg;
      gpio_ctrl_out   <= ioctl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rx_level;
    @(posedge mclk_in) disable iff (rst_in)
      (fifo_en && mask_reg[0] && !src_line && rx_fill >= rx_trig) |=> irq_out;
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("receive level interrupt missing");

  property p_rx_code;
    @(posedge mclk_in) disable iff (rst_in)
      (reg_rd_in && at_setup && !div_acc && !enh_acc && rx_fill < rx_trig) |=> (reg_rdata_out[5:0] != 6'h04);
  endproperty
  a_rx_code: assert property (p_rx_code) else $error("receive code below trigger");

  property p_ready;
    @(posedge mclk_in) disable iff (rst_in)
      (rx_push && !swrst && !wr_fcr) |=> flags[0];
  endproperty
  a_ready: assert property (p_ready) else $error("data ready not set after push");

  property p_overrun;
    @(posedge mclk_in) disable iff (rst_in)
      (rx_push_in && rx_full) |=> overrun_reg [*1] ##0 (flags[1] == 1'b1);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_txboth;
    @(posedge mclk_in) disable iff (rst_in)
      flags[6] |-> (tx_shift_empty_in && flags[5]);
  endproperty
  a_txboth: assert property (p_txboth) else $error("transmit empty flag wrong");

  property p_global;
    @(posedge mclk_in) disable iff (rst_in)
      (push_err && !pop_err && !swrst && !wr_fcr) |=> flags[7];
  endproperty
  a_global: assert property (p_global) else $error("global error flag missing");

  property p_enh_lock;
    @(posedge mclk_in) disable iff (rst_in)
      (wr_mask && !enh_on) |=> (mask_reg[7:4] == $past(mask_reg[7:4]));
  endproperty
  a_enh_lock: assert property (p_enh_lock) else $error("locked mask bits changed");

  property p_gpio;
    @(posedge mclk_in) disable iff (rst_in)
      (gpio_tog != 8'h00) |=> gpio_irq_reg ##1 (gpio_irq_reg || $past(rd_iost));
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio interrupt lost");

  property p_rsvd;
    @(posedge mclk_in) disable iff (rst_in)
      (reg_rd_in && reg_addr_in == `USR_OFS_RSVD) |=> (reg_rvalid_out && reg_rdata_out == 8'h00);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved offset not zero");

endmodule
`default_nettype wire

// File: testbench/usr_far_model.sv
`timescale 1ns/1ns
`default_nettype none

module usr_far_model
  import usr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire usr_byte_t  data_in,
  input  wire logic [2:0] err_in,
  output var  logic       rx_push_out,
  output var  usr_byte_t  rx_data_out,
  output var  logic [2:0] rx_err_out
);

  // One character per request, lines churn between characters
  always_ff @(posedge mclk_in)
  begin
    rx_push_out <= req_in && !rst_in;
    if (rst_in)
    begin
      rx_data_out <= 8'h00;
      rx_err_out  <= 3'h0;
    end
    else if (req_in)
    begin
      rx_data_out <= data_in;
      rx_err_out  <= err_in;
    end
    else
    begin
      rx_data_out <= ~rx_data_out;
      rx_err_out  <= ~rx_err_out;
    end
  end

endmodule

`default_nettype wire

// File: testbench/usr_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module usr_regs_tb_top
  import usr_pkg::*;
;
  logic        mclk_in;
  logic        rst_in;
  logic [3:0]  reg_addr_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  usr_byte_t   reg_wdata_in;
  logic [7:0]  reg_rdata_out;
  logic        reg_rvalid_out;
  logic        rx_push_in;
  usr_byte_t   rx_data_in;
  logic [2:0]  rx_err_in;
  logic        tx_fifo_empty_in;
  logic        tx_shift_empty_in;
  usr_byte_t   gpio_in;
  logic [15:0] baud_div_out;
  logic [7:0]  extra_ctrl_out;
  logic [7:0]  enh_ctrl_out;
  logic [7:0]  frac_div_out;
  logic [7:0]  fifo_setup_out;
  logic [7:0]  tx_data_out;
  logic [3:0]  gpio_ctrl_out;
  logic        irq_out;
  logic        far_req;
  usr_byte_t   far_data;
  logic [2:0]  far_err;
  logic [31:0] seed;
  int          num_errors;
  int          comparisons;
  usr_byte_t   expq[$];
  usr_byte_t   rxq[$];
  usr_byte_t   v;
  usr_byte_t   w;

  ////////////////////////////////////////////////////////////////////////////
  // Design and receive-side model
  usr_regs #(.RX_DEPTH(8)) i_usr_regs (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .rx_push_in(rx_push_in), .rx_data_in(rx_data_in),
    .rx_err_in(rx_err_in), .tx_fifo_empty_in(tx_fifo_empty_in), .tx_shift_empty_in(tx_shift_empty_in),
    .tx_level_in(8'h00), .modem_status_in(8'h00), .modem_event_in(1'b0), .gpio_in(gpio_in),
    .tx_push_out(), .tx_data_out(tx_data_out), .baud_div_out(baud_div_out), .frac_div_out(frac_div_out),
    .line_format_out(), .fifo_setup_out(fifo_setup_out), .modem_ctrl_out(), .enh_ctrl_out(enh_ctrl_out),
    .extra_ctrl_out(extra_ctrl_out), .gpio_out(), .gpio_dir_out(), .gpio_ctrl_out(gpio_ctrl_out),
    .irq_out(irq_out));

  usr_far_model i_usr_far_model (
    .mclk_in(mclk_in), .rst_in(rst_in), .req_in(far_req), .data_in(far_data), .err_in(far_err),
    .rx_push_out(rx_push_in), .rx_data_out(rx_data_in), .rx_err_out(rx_err_in));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic rnd(output usr_byte_t r);
    seed = xs(seed);
    r = seed[7:0];
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register access, a read notes its expected data
  task automatic bus(input logic rd, input logic [3:0] a, input usr_byte_t d);
    @(posedge mclk_in);
    if (rd)
      expq.push_back(d);
    reg_rd_in <= rd;
    reg_wr_in <= !rd;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    reg_wr_in <= 1'b0;
  endtask

  task automatic push(input usr_byte_t d, input logic [2:0] e);
    @(posedge mclk_in);
    far_req <= 1'b1;
    far_data <= d;
    far_err <= e;
    rxq.push_back(d);
    @(posedge mclk_in);
    far_req <= 1'b0;
  endtask

  task automatic idle;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and read-data monitor
  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  initial
  begin
    #80000;
    num_errors++;
    end_sim();
  end

  always @(negedge mclk_in)
    if (reg_rvalid_out === 1'b1)
      check(reg_rdata_out, expq.pop_front());

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 32'h43732b37;
    rst_in = 1'b1;
    reg_addr_in = 4'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_wdata_in = 8'h00;
    far_req = 1'b0;
    far_data = 8'h00;
    far_err = 3'h0;
    tx_fifo_empty_in = 1'b1;
    tx_shift_empty_in = 1'b0;
    num_errors = 0;
    comparisons = 0;
    rnd(v);
    gpio_in = v;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    // Reserved slot and a plain register
    bus(1, 4'hd, 8'h00);
    rnd(v);
    bus(0, 4'hd, v);
    bus(1, 4'hd, 8'h00);
    rnd(v);
    v = v & 8'hb0;
    bus(0, 4'hf, v);
    bus(1, 4'hf, v);
    idle;
    check(extra_ctrl_out, v);
    // Divisor window, fraction still locked
    bus(0, 4'h3, 8'h80);
    rnd(v);
    rnd(w);
    bus(0, 4'h0, v);
    bus(0, 4'h1, w);
    bus(0, 4'h2, 8'h5a);
    bus(1, 4'h0, v);
    bus(1, 4'h1, w);
    bus(1, 4'h2, 8'h00);
    idle;
    check(baud_div_out[7:0], v);
    check(baud_div_out[15:8], w);
    // Enhanced key opens control and flow characters
    bus(0, 4'h3, 8'hbf);
    bus(0, 4'h2, 8'h10);
    rnd(v);
    bus(0, 4'h4, v);
    bus(1, 4'h2, 8'h10);
    bus(1, 4'h4, v);
    bus(0, 4'h3, 8'h80);
    bus(0, 4'h2, 8'h5a);
    bus(1, 4'h2, 8'h5a);
    bus(0, 4'h3, 8'h03);
    bus(1, 4'h4, 8'h00);
    idle;
    check(enh_ctrl_out, 8'h10);
    check(frac_div_out, 8'h5a);
    // Holding write with the divisor window closed
    rnd(v);
    bus(0, 4'h0, v);
    idle;
    check(tx_data_out, v);
    // FIFO on, errored then clean character
    bus(0, 4'h2, 8'h01);
    idle;
    check(fifo_setup_out, 8'h01);
    bus(1, 4'h5, 8'h20);
    rnd(v);
    push(v, 3'b001);
    rnd(v);
    push(v, 3'b000);
    idle;
    bus(1, 4'h5, 8'ha5);
    bus(1, 4'h0, rxq.pop_front());
    bus(1, 4'h5, 8'h21);
    bus(1, 4'h0, rxq.pop_front());
    tx_shift_empty_in <= 1'b1;
    bus(1, 4'h5, 8'h60);
    // Receive trigger at eight characters
    bus(0, 4'h1, 8'h01);
    repeat (7)
    begin
      rnd(v);
      push(v, 3'b000);
    end
    idle;
    check({7'h00, irq_out}, 8'h00);
    bus(1, 4'h2, 8'hc1);
    rnd(v);
    push(v, 3'b000);
    idle;
    check({7'h00, irq_out}, 8'h01);
    bus(1, 4'h2, 8'hc4);
    bus(1, 4'h0, rxq.pop_front());
    idle;
    check({7'h00, irq_out}, 8'h00);
    bus(1, 4'h2, 8'hc1);
    // Overrun on a full FIFO
    rnd(v);
    push(v, 3'b000);
    rnd(v);
    push(v, 3'b000);
    idle;
    bus(1, 4'h5, 8'h63);
    bus(1, 4'h5, 8'h61);
    // Polled mode with the mask cleared
    bus(0, 4'h1, 8'h00);
    idle;
    check({7'h00, irq_out}, 8'h00);
    bus(1, 4'h2, 8'hc1);
    bus(1, 4'h5, 8'h61);
    // Enabled input toggles, pin read clears
    bus(0, 4'hc, 8'h01);
    gpio_in <= gpio_in ^ 8'h01;
    idle;
    check({7'h00, irq_out}, 8'h01);
    bus(1, 4'h2, 8'hf0);
    bus(1, 4'hb, gpio_in);
    idle;
    check({7'h00, irq_out}, 8'h00);
    // Software reset empties the receive FIFO and self-clears
    bus(0, 4'he, 8'h0e);
    bus(1, 4'h9, 8'h00);
    bus(1, 4'h5, 8'h60);
    idle;
    check({4'h0, gpio_ctrl_out}, 8'h06);
    end_sim();
  end

endmodule

`default_nettype wire
